// ### mlsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mlsc_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_ack_out,
  input wire logic token_own_in,
  input wire logic req_ok_in,
  input wire logic req_bad_in,
  input wire logic ring_drop_in,
  input wire logic comm_err_in,
  input wire logic proto_err_in,
  input wire logic link_enable_out,
  input wire logic tx_allow_out,
  input wire logic [7:0] display_code_out,
  input wire logic minor_fault_output_out,
  input wire logic link_timeout_fault_out,
  input wire logic output_shutoff_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Bus writes race with events, so event checks exclude them
  logic quiet;
  assign quiet = ce_in && !(wb_cyc_in && wb_we_in);
  AST_ACK_ONE: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_SHUTOFF: assert property ($rose(link_timeout_fault_out) |-> output_shutoff_out)
    else $error("timeout without output shutoff");
  AST_LOSS_MINOR: assert property (link_timeout_fault_out |-> minor_fault_output_out)
    else $error("timeout without minor fault");
  AST_MINOR_CODE: assert property (display_code_out != 8'h00 && $stable(display_code_out)
    && !link_timeout_fault_out |-> minor_fault_output_out
    == (display_code_out == 8'h5A || display_code_out == 8'h5B))
    else $error("minor fault disagrees with code");
  AST_TOKEN_OWN: assert property (token_own_in && quiet && link_enable_out
    && display_code_out == 8'h02 && !comm_err_in && !proto_err_in && !req_ok_in
    && !req_bad_in && !ring_drop_in |-> ##[1:2] display_code_out == 8'h0A)
    else $error("own token code missing");
  AST_COMM_ERR: assert property (comm_err_in && !proto_err_in && quiet && link_enable_out
    && display_code_out >= 8'h02 |-> ##[1:2] display_code_out == 8'h5A)
    else $error("comm error code missing");
  AST_TX_ENABLE: assert property (tx_allow_out |-> link_enable_out)
    else $error("transmit allowed while link disabled");
  AST_AUTO_QUIET: assert property (display_code_out == 8'h01 |-> !tx_allow_out)
    else $error("transmit allowed during rate search");
  AST_PENDING: assert property (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && ce_in
    && wb_sel_in[0] && wb_adr_in == 8'h0C |-> ##2 !link_enable_out)
    else $error("link stays enabled after rate change");
endmodule : mlsc_checker
bind mlsc_top mlsc_checker i_chk (.clk_in, .rst_b_in, .ce_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_ack_out, .token_own_in, .req_ok_in, .req_bad_in,
  .ring_drop_in, .comm_err_in, .proto_err_in, .link_enable_out, .tx_allow_out,
  .display_code_out, .minor_fault_output_out, .link_timeout_fault_out, .output_shutoff_out);
`default_nettype wire

// ### mlsc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module mlsc_peer #(
  parameter int GAP = 20
) (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [9:0] ev_in,
  input wire logic keep_in,
  output logic [9:0] ev_out
);
  int cnt = 0;
  // ----------------------------------------
  // Frames seen on the shared bus
  // ----------------------------------------
  // Own and foreign tokens arrive as separate one-cycle events
  always_ff @(posedge clk_in) begin
    cnt <= (keep_in && cnt < GAP - 1) ? cnt + 1 : 0;
    ev_out <= go_in ? ev_in : 10'h000;
    // Host talks inside every check interval
    if (keep_in && cnt == GAP - 1) begin
      ev_out[0] <= 1'b1;
    end
  end
endmodule : mlsc_peer
`default_nettype wire

// ### mlsc_pkg.sv
package mlsc_pkg;
  typedef enum logic [1:0] {
    MLSC_ST_IDLE,
    MLSC_ST_AUTOBAUD,
    MLSC_ST_WAIT,
    MLSC_ST_JOINED
  } mlsc_link_state_type;
endpackage : mlsc_pkg

// ### mlsc_regs.svh
// Functional notes
// - Six rates 9600..115200, 8N1 NRZ frames
// - Master only, node address 0..127
// - Transmit only while holding the token
// - Display status code when monitor select 81
// - Code 0 never talked, 1 autobaud; no errors counted
// - Code 2 while waiting for own token
// - Code 10 on token to own node
// - Own requests: 11 supported, 12 unsupported
// - Code 20 foreign token, 30 dropped from ring
// - Code 90 comm error, 91 protocol violation
// - Of the codes, minor fault only for 90 and 91
// - Watchdog expiry raises timeout fault, output off
// - Signal loss also asserts minor fault
// - Interval 9999 disables loss checking
// - Interval 0: fault at network mode entry
// - Interval 0.1..999.8 s enables watchdog
// - Any received data clears watchdog counter
// - Watchdog starts at first frame in network mode
// - Settings apply after reset; silent until then
// - Out of range setting acts as initial value
// - Autobaud switches link to detected rate
// - Autobaud 128..255 recognises, else stored rate
// - Never drive bus during rate recognition
`ifndef MLSC_REGS_SVH
`define MLSC_REGS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define MLSC_CLK_HZ 200000000
`define MLSC_WDOG_STEP_MS 100
`define MLSC_WDOG_STEP_CYC (`MLSC_CLK_HZ / 1000 * `MLSC_WDOG_STEP_MS)
`define MLSC_BAUD_0 9600
`define MLSC_BAUD_1 19200
`define MLSC_BAUD_2 38400
`define MLSC_BAUD_3 57600
`define MLSC_BAUD_4 76800
`define MLSC_BAUD_5 115200
`define MLSC_BAUD_MAX_IDX 3'h5
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MLSC_OFS_NODE 8'h00
`define MLSC_OFS_MON_SEL 8'h04
`define MLSC_OFS_LOSS 8'h08
`define MLSC_OFS_BAUD 8'h0C
`define MLSC_OFS_AUTO 8'h10
`define MLSC_OFS_MODE 8'h14
`define MLSC_OFS_RESET 8'h18
`define MLSC_OFS_STATUS 8'h1C
`define MLSC_OFS_DISPLAY 8'h20
`define MLSC_OFS_ERRCNT 8'h24
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define MLSC_RST_NODE 8'h00
`define MLSC_RST_MON_SEL 16'h0000
`define MLSC_RST_LOSS 16'h270F
`define MLSC_RST_BAUD 3'h0
`define MLSC_RST_AUTO 8'h00
`define MLSC_NODE_MAX 8'h7F
`define MLSC_LOSS_OFF 16'h270F
`define MLSC_AUTO_ON_BIT 7
`define MLSC_MON_STATUS 16'h0051
// ----------------------------------------
// Status field positions and codes
// ----------------------------------------
`define MLSC_ST_CODE_LSB 0
`define MLSC_ST_MINOR_BIT 8
`define MLSC_ST_TMO_BIT 9
`define MLSC_ST_PEND_BIT 10
`define MLSC_ST_TOKEN_BIT 11
`define MLSC_ST_BAUD_LSB 12
`define MLSC_CODE_IDLE 8'h00
`define MLSC_CODE_AUTOBAUD 8'h01
`define MLSC_CODE_WAIT 8'h02
`define MLSC_CODE_TOKEN_OWN 8'h0A
`define MLSC_CODE_REQ_OK 8'h0B
`define MLSC_CODE_REQ_BAD 8'h0C
`define MLSC_CODE_TOKEN_OTHER 8'h14
`define MLSC_CODE_SEPARATED 8'h1E
`define MLSC_CODE_COMM_ERR 8'h5A
`define MLSC_CODE_PROTO_ERR 8'h5B
`endif

// ### mlsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mlsc_regs.svh"
module mlsc_top #(
  parameter int WDOG_STEP_CYC = `MLSC_WDOG_STEP_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // ----------------------------------------
  // Events from the frame decoder
  // ----------------------------------------
  input wire logic rx_frame_in,
  input wire logic token_own_in,
  input wire logic token_other_in,
  input wire logic token_pass_in,
  input wire logic req_ok_in,
  input wire logic req_bad_in,
  input wire logic ring_drop_in,
  input wire logic comm_err_in,
  input wire logic proto_err_in,
  input wire logic baud_found_in,
  input wire logic [2:0] baud_found_idx_in,
  // ----------------------------------------
  // Link and inverter side
  // ----------------------------------------
  output logic [6:0] node_addr_out,
  output logic [2:0] baud_idx_out,
  output logic bit_tick_out,
  output logic link_enable_out,
  output logic tx_allow_out,
  output logic [7:0] display_code_out,
  output logic minor_fault_output_out,
  output logic link_timeout_fault_out,
  output logic output_shutoff_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] baud_div(input logic [2:0] idx);
    case (idx)
      3'h0: baud_div = 16'(`MLSC_CLK_HZ / `MLSC_BAUD_0);
      3'h1: baud_div = 16'(`MLSC_CLK_HZ / `MLSC_BAUD_1);
      3'h2: baud_div = 16'(`MLSC_CLK_HZ / `MLSC_BAUD_2);
      3'h3: baud_div = 16'(`MLSC_CLK_HZ / `MLSC_BAUD_3);
      3'h4: baud_div = 16'(`MLSC_CLK_HZ / `MLSC_BAUD_4);
      default: baud_div = 16'(`MLSC_CLK_HZ / `MLSC_BAUD_5);
    endcase
  endfunction : baud_div

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  function automatic logic [15:0] fix_loss(input logic [15:0] v);
    fix_loss = (v > `MLSC_LOSS_OFF) ? `MLSC_RST_LOSS : v;
  endfunction : fix_loss

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] node_set;
    logic [15:0] mon_sel;
    logic [15:0] loss_set;
    logic [2:0] baud_set;
    logic [7:0] auto_set;
    logic net_mode;
    logic loaded;
    logic pending;
    logic [6:0] act_node;
    logic [15:0] act_loss;
    logic [2:0] act_baud;
    logic act_auto;
    mlsc_pkg::mlsc_link_state_type lstate;
    logic [7:0] code;
    logic [15:0] errcnt;
    logic token_held;
    logic wd_started;
    logic timeout;
    logic [15:0] div_cnt;
    logic bit_tick;
  } mlsc_top_state_type;

  mlsc_top_state_type s_q, s_d;
  logic wd_expire;
  logic wd_arm;
  logic wr_req;
  logic rd_req;
  logic soft_reset;

  assign wd_arm = s_q.wd_started && s_q.net_mode && !s_q.pending
                  && s_q.act_loss != `MLSC_LOSS_OFF && s_q.act_loss != 16'h0000;

  mlsc_wdog #(
    .STEP_CYC(WDOG_STEP_CYC)
  ) u_wdog (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .arm_in(wd_arm),
    .clear_in(rx_frame_in),
    .interval_in(s_q.act_loss),
    .expire_out(wd_expire)
  );

  always_comb begin
    s_d = s_q;
    wr_req = wb_cyc_in && wb_stb_in && wb_we_in && !s_q.ack;
    rd_req = wb_cyc_in && wb_stb_in && !wb_we_in && !s_q.ack;
    soft_reset = 1'b0;
    s_d.ack = wb_cyc_in && wb_stb_in && !s_q.ack;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (wr_req) begin
      if (wb_adr_in == `MLSC_OFS_NODE) begin
        if (wb_sel_in[0]) begin
          s_d.node_set = wb_dat_in[7:0];
          s_d.pending = 1'b1;
        end
      end else if (wb_adr_in == `MLSC_OFS_MON_SEL) begin
        s_d.mon_sel = merge16(s_q.mon_sel, wb_dat_in, wb_sel_in);
      end else if (wb_adr_in == `MLSC_OFS_LOSS) begin
        s_d.loss_set = merge16(s_q.loss_set, wb_dat_in, wb_sel_in);
        s_d.pending = 1'b1;
      end else if (wb_adr_in == `MLSC_OFS_BAUD) begin
        if (wb_sel_in[0]) begin
          s_d.baud_set = wb_dat_in[2:0];
          s_d.pending = 1'b1;
        end
      end else if (wb_adr_in == `MLSC_OFS_AUTO) begin
        if (wb_sel_in[0]) begin
          s_d.auto_set = wb_dat_in[7:0];
          s_d.pending = 1'b1;
        end
      end else if (wb_adr_in == `MLSC_OFS_MODE) begin
        if (wb_sel_in[0]) begin
          s_d.net_mode = wb_dat_in[0];
        end
      end else if (wb_adr_in == `MLSC_OFS_RESET) begin
        soft_reset = wb_sel_in[0] && wb_dat_in[0];
      end
    end

    // ----------------------------------------
    // Register reads, unmapped reads as zero
    // ----------------------------------------
    if (rd_req) begin
      s_d.rdat = 32'h00000000;
      if (wb_adr_in == `MLSC_OFS_NODE) begin
        s_d.rdat[7:0] = s_q.node_set;
      end else if (wb_adr_in == `MLSC_OFS_MON_SEL) begin
        s_d.rdat[15:0] = s_q.mon_sel;
      end else if (wb_adr_in == `MLSC_OFS_LOSS) begin
        s_d.rdat[15:0] = s_q.loss_set;
      end else if (wb_adr_in == `MLSC_OFS_BAUD) begin
        s_d.rdat[2:0] = s_q.baud_set;
      end else if (wb_adr_in == `MLSC_OFS_AUTO) begin
        s_d.rdat[7:0] = s_q.auto_set;
      end else if (wb_adr_in == `MLSC_OFS_MODE) begin
        s_d.rdat[0] = s_q.net_mode;
      end else if (wb_adr_in == `MLSC_OFS_STATUS) begin
        s_d.rdat[`MLSC_ST_CODE_LSB +: 8] = s_q.code;
        s_d.rdat[`MLSC_ST_MINOR_BIT] = minor_fault_output_out;
        s_d.rdat[`MLSC_ST_TMO_BIT] = s_q.timeout;
        s_d.rdat[`MLSC_ST_PEND_BIT] = s_q.pending;
        s_d.rdat[`MLSC_ST_TOKEN_BIT] = s_q.token_held;
        s_d.rdat[`MLSC_ST_BAUD_LSB +: 3] = s_q.act_baud;
      end else if (wb_adr_in == `MLSC_OFS_DISPLAY) begin
        s_d.rdat[7:0] = display_code_out;
      end else if (wb_adr_in == `MLSC_OFS_ERRCNT) begin
        s_d.rdat[15:0] = s_q.errcnt;
      end
    end

    // ----------------------------------------
    // Apply settings at reset release or soft reset
    // ----------------------------------------
    if (!s_q.loaded || soft_reset) begin
      s_d.loaded = 1'b1;
      s_d.pending = 1'b0;
      s_d.act_node = (s_q.node_set > `MLSC_NODE_MAX) ? 7'(`MLSC_RST_NODE)
                     : s_q.node_set[6:0];
      s_d.act_loss = fix_loss(s_q.loss_set);
      s_d.act_baud = (s_q.baud_set > `MLSC_BAUD_MAX_IDX) ? `MLSC_RST_BAUD
                     : s_q.baud_set;
      s_d.act_auto = s_q.auto_set[`MLSC_AUTO_ON_BIT];
      s_d.lstate = s_q.auto_set[`MLSC_AUTO_ON_BIT] ? mlsc_pkg::MLSC_ST_AUTOBAUD
                   : mlsc_pkg::MLSC_ST_IDLE;
      s_d.code = s_q.auto_set[`MLSC_AUTO_ON_BIT] ? `MLSC_CODE_AUTOBAUD
                 : `MLSC_CODE_IDLE;
      s_d.token_held = 1'b0;
      s_d.wd_started = 1'b0;
      s_d.timeout = 1'b0;
      s_d.errcnt = 16'h0000;
    end else if (!s_q.pending) begin
      // Link state; silent while settings wait for a reset
      case (s_q.lstate)
        mlsc_pkg::MLSC_ST_IDLE: begin
          if (rx_frame_in) begin
            s_d.lstate = mlsc_pkg::MLSC_ST_WAIT;
            s_d.code = `MLSC_CODE_WAIT;
          end
        end
        mlsc_pkg::MLSC_ST_AUTOBAUD: begin
          // Errors here are ignored: wrong rate garbles everything
          if (baud_found_in && baud_found_idx_in <= `MLSC_BAUD_MAX_IDX) begin
            s_d.act_baud = baud_found_idx_in;
            s_d.baud_set = baud_found_idx_in;
            s_d.lstate = mlsc_pkg::MLSC_ST_WAIT;
            s_d.code = `MLSC_CODE_WAIT;
          end
        end
        mlsc_pkg::MLSC_ST_WAIT: begin
          if (token_own_in) begin
            s_d.lstate = mlsc_pkg::MLSC_ST_JOINED;
          end
        end
        mlsc_pkg::MLSC_ST_JOINED: begin
          if (ring_drop_in) begin
            s_d.lstate = mlsc_pkg::MLSC_ST_WAIT;
          end
        end
        default: begin
          s_d.lstate = mlsc_pkg::MLSC_ST_IDLE;
        end
      endcase

      // Latest event sets the code; errors take priority
      if (s_q.lstate != mlsc_pkg::MLSC_ST_AUTOBAUD
          && s_q.lstate != mlsc_pkg::MLSC_ST_IDLE) begin
        if (proto_err_in) begin
          s_d.code = `MLSC_CODE_PROTO_ERR;
        end else if (comm_err_in) begin
          s_d.code = `MLSC_CODE_COMM_ERR;
        end else if (ring_drop_in && s_q.lstate == mlsc_pkg::MLSC_ST_JOINED) begin
          s_d.code = `MLSC_CODE_SEPARATED;
        end else if (req_bad_in) begin
          s_d.code = `MLSC_CODE_REQ_BAD;
        end else if (req_ok_in) begin
          s_d.code = `MLSC_CODE_REQ_OK;
        end else if (token_own_in) begin
          s_d.code = `MLSC_CODE_TOKEN_OWN;
        end else if (token_other_in) begin
          s_d.code = `MLSC_CODE_TOKEN_OTHER;
        end
        if ((comm_err_in || proto_err_in) && s_q.errcnt != 16'hFFFF) begin
          s_d.errcnt = s_q.errcnt + 16'h0001;
        end
      end

      // Token ownership gates transmission
      if (token_pass_in || ring_drop_in) begin
        s_d.token_held = 1'b0;
      end else if (token_own_in && s_q.lstate != mlsc_pkg::MLSC_ST_AUTOBAUD) begin
        s_d.token_held = 1'b1;
      end

      // ----------------------------------------
      // Signal loss supervision
      // ----------------------------------------
      if (!s_q.net_mode) begin
        s_d.wd_started = 1'b0;
      end else if (rx_frame_in) begin
        s_d.wd_started = 1'b1;
      end
      if (s_q.net_mode && s_q.act_loss == 16'h0000) begin
        s_d.timeout = 1'b1;
      end
      // Expiry counts only while armed; a stale one is ignored
      if (wd_expire && wd_arm) begin
        s_d.timeout = 1'b1;
      end
    end

    // ----------------------------------------
    // Bit rate tick
    // ----------------------------------------
    // Integer divide: rate error stays far below a tenth of a percent
    if (s_q.div_cnt >= baud_div(s_q.act_baud) - 16'h0001) begin
      s_d.div_cnt = 16'h0000;
      s_d.bit_tick = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 16'h0001;
      s_d.bit_tick = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
      s_q.node_set <= `MLSC_RST_NODE;
      s_q.mon_sel <= `MLSC_RST_MON_SEL;
      s_q.loss_set <= `MLSC_RST_LOSS;
      s_q.baud_set <= `MLSC_RST_BAUD;
      s_q.auto_set <= `MLSC_RST_AUTO;
      s_q.act_loss <= `MLSC_RST_LOSS;
      s_q.act_baud <= `MLSC_RST_BAUD;
      s_q.lstate <= mlsc_pkg::MLSC_ST_IDLE;
      s_q.code <= `MLSC_CODE_IDLE;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_out = s_q.ack;
  assign wb_dat_out = s_q.rdat;
  assign node_addr_out = s_q.act_node;
  assign baud_idx_out = s_q.act_baud;
  assign bit_tick_out = s_q.bit_tick;
  assign link_enable_out = s_q.loaded && !s_q.pending;
  assign tx_allow_out = s_q.loaded && !s_q.pending && s_q.token_held
                        && s_q.lstate != mlsc_pkg::MLSC_ST_AUTOBAUD;
  assign display_code_out = (s_q.mon_sel == `MLSC_MON_STATUS) ? s_q.code
                            : 8'h00;
  assign minor_fault_output_out = s_q.code == `MLSC_CODE_COMM_ERR
                                  || s_q.code == `MLSC_CODE_PROTO_ERR
                                  || s_q.timeout;
  assign link_timeout_fault_out = s_q.timeout;
  assign output_shutoff_out = s_q.timeout;
endmodule : mlsc_top
`default_nettype wire

// ### mlsc_wdog.sv
`timescale 1ns/1ps
`default_nettype none
module mlsc_wdog #(
  parameter int STEP_CYC = 20000000
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic arm_in,
  input wire logic clear_in,
  input wire logic [15:0] interval_in,
  output logic expire_out
);
  typedef struct packed {
    logic [24:0] step;
    logic [15:0] ticks;
    logic expire;
  } mlsc_wdog_state_type;

  mlsc_wdog_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!arm_in) begin
      // Disarming drops expiry, so a soft reset cannot re-trip
      s_d.step = 25'h0000000;
      s_d.ticks = 16'h0000;
      s_d.expire = 1'b0;
    end else if (clear_in) begin
      s_d.step = 25'h0000000;
      s_d.ticks = 16'h0000;
    end else if (!s_q.expire) begin
      if (s_q.step == 25'(STEP_CYC - 1)) begin
        s_d.step = 25'h0000000;
        s_d.ticks = s_q.ticks + 16'h0001;
        if (s_q.ticks + 16'h0001 >= interval_in) begin
          s_d.expire = 1'b1;
        end
      end else begin
        s_d.step = s_q.step + 25'h0000001;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign expire_out = s_q.expire;
endmodule : mlsc_wdog
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mlsc_regs.svh"
module tb;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic go = 1'b0;
  logic keep = 1'b0;
  logic [9:0] ev = 10'h000;
  logic [2:0] fidx = 3'h0;
  logic [9:0] pev;
  logic [31:0] rdat, q;
  logic [6:0] node;
  logic [2:0] bidx;
  logic [7:0] disp;
  logic ack, tick, len, txa, minor, tmo, shut;
  int failures = 0;
  int checks = 0;
  int code = 0;
  int joined = 0;
  int nd;
  logic [9:0] seq [12] = '{10'h002, 10'h001, 10'h002, 10'h010, 10'h020, 10'h004,
    10'h040, 10'h080, 10'h100, 10'h180, 10'h002, 10'h004};
  always #2.5 clk_in = ~clk_in;
  mlsc_top #(.WDOG_STEP_CYC(10)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat),
    .wb_sel_in(sel), .wb_dat_out(rdat), .wb_ack_out(ack), .rx_frame_in(pev[0]),
    .token_own_in(pev[1]), .token_other_in(pev[2]), .token_pass_in(pev[3]),
    .req_ok_in(pev[4]), .req_bad_in(pev[5]), .ring_drop_in(pev[6]), .comm_err_in(pev[7]),
    .proto_err_in(pev[8]), .baud_found_in(pev[9]), .baud_found_idx_in(fidx),
    .node_addr_out(node), .baud_idx_out(bidx), .bit_tick_out(tick), .link_enable_out(len),
    .tx_allow_out(txa), .display_code_out(disp), .minor_fault_output_out(minor),
    .link_timeout_fault_out(tmo), .output_shutoff_out(shut));
  mlsc_peer #(.GAP(20)) i_peer (.clk_in(clk_in), .go_in(go), .ev_in(ev), .keep_in(keep),
    .ev_out(pev));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // Request holds until ack is seen at a rising edge; data taken there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_in);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(negedge clk_in);
  endtask : wb
  task automatic srst;
    wb(1'b1, `MLSC_OFS_RESET, 32'h1);
    repeat (3) @(negedge clk_in);
  endtask : srst
  task automatic pulse(input logic [9:0] v);
    @(posedge clk_in);
    ev <= v;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
  endtask : pulse
  function automatic int model(input logic [9:0] v);
    if (code == 1) return v[9] ? 2 : 1;
    if (code == 0) return v[0] ? 2 : 0;
    if (v[8]) return 91;
    if (v[7]) return 90;
    if (v[6] && joined != 0) return 30;
    if (v[5]) return 12;
    if (v[4]) return 11;
    if (v[1]) return 10;
    if (v[2]) return 20;
    return code;
  endfunction : model
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(68));
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    wb(1'b0, `MLSC_OFS_LOSS, 32'h0);
    chk(q, 32'h270F, "loss reset");
    wb(1'b0, 8'h3C, 32'h0);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, `MLSC_OFS_MON_SEL, 32'h51);
    chk(disp, 32'h0, "idle code");
    foreach (seq[i]) begin
      code = model(seq[i]);
      joined = seq[i][1] ? 1 : (seq[i][6] ? 0 : joined);
      pulse(seq[i]);
      chk(disp, code, "status code");
      chk(minor, code >= 90, "minor fault");
    end
    chk(txa, 1'b1, "tx after own token");
    pulse(10'h008);
    chk(txa, 1'b0, "token passed on");
    nd = $urandom_range(80, 0);
    wb(1'b1, `MLSC_OFS_MON_SEL, nd);
    chk(disp, 32'h0, "display off");
    wb(1'b1, `MLSC_OFS_MON_SEL, 32'h51);
    wb(1'b1, `MLSC_OFS_BAUD, 32'h5);
    chk(len, 1'b0, "pending link");
    pulse(10'h002);
    chk(disp, 32'h14, "event while pending");
    nd = $urandom_range(127, 0);
    wb(1'b1, `MLSC_OFS_NODE, nd);
    srst();
    chk(bidx, 32'h5, "applied rate");
    chk(node, nd, "applied node");
    chk(len, 1'b1, "link after reset");
    do begin
      @(negedge clk_in);
    end while (tick !== 1'b1);
    nd = 0;
    do begin
      @(negedge clk_in);
      nd++;
    end while (tick !== 1'b1);
    chk(nd, `MLSC_CLK_HZ / `MLSC_BAUD_5, "bit period");
    wb(1'b1, `MLSC_OFS_BAUD, 32'h7);
    wb(1'b1, `MLSC_OFS_NODE, 32'hC8);
    srst();
    chk(bidx, 32'h0, "rate out of range");
    chk(node, 32'h0, "node out of range");
    wb(1'b1, `MLSC_OFS_AUTO, 32'h80 | $urandom_range(127, 0));
    srst();
    code = 1;
    chk(disp, 32'h1, "rate search code");
    chk(txa, 1'b0, "silent in search");
    pulse(10'h080);
    chk(disp, 32'h1, "error in search");
    wb(1'b0, `MLSC_OFS_ERRCNT, 32'h0);
    chk(q, 32'h0, "error count");
    @(posedge clk_in);
    fidx <= 3'($urandom_range(5, 0));
    pulse(10'h200);
    chk(disp, 32'h2, "rate found code");
    chk(bidx, fidx, "rate found");
    wb(1'b1, `MLSC_OFS_AUTO, 32'h0);
    wb(1'b1, `MLSC_OFS_LOSS, 32'h3);
    srst();
    wb(1'b1, `MLSC_OFS_MODE, 32'h1);
    repeat (100) @(negedge clk_in);
    chk(tmo, 1'b0, "no start before frame");
    @(posedge clk_in);
    keep <= 1'b1;
    repeat (200) @(negedge clk_in);
    chk(tmo, 1'b0, "kept alive");
    @(posedge clk_in);
    keep <= 1'b0;
    pulse(10'h001);
    repeat (27) @(negedge clk_in);
    chk(tmo, 1'b0, "before interval");
    @(negedge clk_in);
    chk(tmo, 1'b1, "loss timeout");
    chk(shut, 1'b1, "output off");
    chk(minor, 1'b1, "loss minor");
    wb(1'b1, `MLSC_OFS_MODE, 32'h0);
    wb(1'b1, `MLSC_OFS_LOSS, 32'h0);
    srst();
    chk(tmo, 1'b0, "cleared by reset");
    wb(1'b0, `MLSC_OFS_LOSS, 32'h0);
    chk(q, 32'h0, "read at zero");
    wb(1'b1, `MLSC_OFS_MODE, 32'h1);
    repeat (2) @(negedge clk_in);
    chk(tmo, 1'b1, "zero interval trip");
    wb(1'b1, `MLSC_OFS_MODE, 32'h0);
    wb(1'b1, `MLSC_OFS_LOSS, 32'h270F);
    srst();
    wb(1'b1, `MLSC_OFS_MODE, 32'h1);
    pulse(10'h001);
    repeat (200) @(negedge clk_in);
    chk(tmo, 1'b0, "check off");
    @(posedge clk_in);
    ce_in <= 1'b0;
    pulse(10'h002);
    chk(disp, 32'h2, "frozen by enable");
    chk(txa, 1'b0, "no token while frozen");
    @(posedge clk_in);
    ce_in <= 1'b1;
    pulse(10'h002);
    chk(disp, 32'hA, "token after enable");
    final_report();
  end
  // Whole run is a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    final_report();
  end
endmodule : tb
`default_nettype wire
